// ==== rtc_pkg.sv ====
// Purpose: shared constants for the timekeeping and configuration register block
// Assumes: 40 MHz system clock, 32.768 kHz timebase sampled as a level
// Notes: register offsets are the byte addresses of the documented port

package rtc_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] ADDR_FRAC = 8'h00;
  localparam logic [7:0] ADDR_SEC = 8'h01;
  localparam logic [7:0] ADDR_MIN = 8'h02;
  localparam logic [7:0] ADDR_HOUR = 8'h03;
  localparam logic [7:0] ADDR_WDAY = 8'h04;
  localparam logic [7:0] ADDR_DATE = 8'h05;
  localparam logic [7:0] ADDR_MONTH = 8'h06;
  localparam logic [7:0] ADDR_YEAR = 8'h07;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_TRIM = 8'h09;
  localparam logic [7:0] ADDR_A0SEC = 8'h0C;
  localparam logic [7:0] ADDR_A0MIN = 8'h0D;

  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_RUN_REQ = 7;
  localparam int BIT_TRIM_DIR = 7;
  localparam int BIT_FMT12 = 6;
  localparam int BIT_PM = 5;
  localparam int BIT_OSC_ON = 5;
  localparam int BIT_BATT = 4;
  localparam int BIT_BKUP_EN = 3;
  localparam int BIT_LEAP = 5;
  localparam int BIT_POL = 7;
  localparam int BIT_SQUARE_WAVE_ENABLE = 6;
  localparam int BIT_EXT = 3;
  localparam int BIT_RS2 = 2;

  // ****************************************
  // reset values and BCD limits
  // ****************************************
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_ONE = 8'h01;
  localparam logic [7:0] BCD_99 = 8'h99;
  localparam logic [7:0] BCD_59 = 8'h59;
  localparam logic [7:0] BCD_23 = 8'h23;
  localparam logic [7:0] BCD_11 = 8'h11;
  localparam logic [7:0] BCD_12 = 8'h12;
  localparam logic [7:0] BCD_7 = 8'h07;

  // ****************************************
  // rate codes and timing
  // ****************************************
  localparam logic [1:0] RS_1HZ = 2'h0;
  localparam logic [1:0] RS_4K = 2'h1;
  localparam logic [1:0] RS_8K = 2'h2;
  localparam logic [1:0] RS_32K = 2'h3;
  localparam logic [5:0] OSC_START_CYCLES = 6'h20;
  localparam int SYS_CLK_NS = 25;
  localparam int OSC_STALL_NS = 100000;
  localparam logic [11:0] OSC_STALL_CYC = 12'(OSC_STALL_NS / SYS_CLK_NS);
  localparam logic [15:0] HUND_STEP = 16'h0064;
  localparam logic [15:0] OSC_HZ = 16'h8000;

endpackage : rtc_pkg

// ==== osc_if.sv ====
// Purpose: carries timebase signals between the register core and its helpers
// Assumes: single clock domain
// Notes: trim and rate come from the core, ticks from the helpers
`timescale 1ns/1ps
`default_nettype none

interface osc_if;
  logic ce;
  logic run_req;
  logic src_level;
  logic src_rise;
  logic running;
  logic trim_neg;
  logic [7:0] trim_val;
  logic minute_pulse;
  logic [2:0] rate;
  logic hund_tick;
  logic sq_level;

  modport core (output ce, run_req, src_level, trim_neg, trim_val, minute_pulse, rate,
                input src_rise, running, hund_tick, sq_level);
  modport monitor (input ce, run_req, src_level, output src_rise, running);
  modport prescale (input ce, src_rise, src_level, trim_neg, trim_val, minute_pulse, rate,
                    output hund_tick, sq_level);
endinterface : osc_if

`default_nettype wire

// ==== osc_monitor.sv ====
// Purpose: detects timebase edges and reports whether the oscillator runs
// Assumes: timebase level is synchronous to sys_clk_i
// Notes: status drops on stop request or after a stall timeout
`timescale 1ns/1ps
`default_nettype none

module osc_monitor (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // timebase link
  osc_if.monitor osc
);

  typedef struct packed {
    logic prev;
    logic [5:0] cnt;
    logic [11:0] idle;
    logic running;
  } mon_state_t;

  mon_state_t s_q;
  mon_state_t s_d;

  // rising edge of the running timebase
  assign osc.src_rise = osc.run_req & osc.src_level & ~s_q.prev;
  assign osc.running = s_q.running;

  // start count and stall watch
  always_comb
  begin
    s_d = s_q;
    if (osc.ce)
    begin
      s_d.prev = osc.src_level;
      if (!osc.run_req)
      begin
        s_d.cnt = 6'h00;
        s_d.running = 1'b0;
        s_d.idle = 12'h000;
      end
      else if (osc.src_rise)
      begin
        s_d.idle = 12'h000;
        if (s_q.cnt != rtc_pkg::OSC_START_CYCLES)
          s_d.cnt = s_q.cnt + 6'h01;
        if (s_q.cnt == rtc_pkg::OSC_START_CYCLES - 6'h01)
          s_d.running = 1'b1;
      end
      else if (s_q.idle == rtc_pkg::OSC_STALL_CYC)
      begin
        s_d.cnt = 6'h00;
        s_d.running = 1'b0;
      end
      else
        s_d.idle = s_q.idle + 12'h001;
    end
  end

  // state register
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

endmodule : osc_monitor

`default_nettype wire

// ==== osc_prescaler.sv ====
// Purpose: trims the timebase, makes the 100 Hz tick and the pin waveforms
// Assumes: one rising edge per timebase cycle on src_rise
// Notes: trim clocks are injected or swallowed right after each minute
`timescale 1ns/1ps
`default_nettype none

module osc_prescaler (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // timebase link
  osc_if.prescale osc
);

  typedef struct packed {
    logic [8:0] pend;
    logic [14:0] div;
    logic [14:0] acc;
  } pre_state_t;

  pre_state_t s_q;
  pre_state_t s_d;
  logic eff_tick;
  logic [15:0] acc_sum;

  // trimmed tick: extra ticks when positive, swallowed ones when negative
  always_comb
  begin
    if (s_q.pend == 9'h000)
      eff_tick = osc.src_rise;
    else if (osc.trim_neg)
      eff_tick = 1'b0;
    else
      eff_tick = 1'b1;
  end

  assign acc_sum = {1'b0, s_q.acc} + rtc_pkg::HUND_STEP;
  assign osc.hund_tick = osc.ce & eff_tick & (acc_sum >= rtc_pkg::OSC_HZ);

  // rate selection, calibration output uses the 1 Hz tap
  always_comb
  begin
    if (osc.rate[rtc_pkg::BIT_RS2])
      osc.sq_level = s_q.div[14];
    else
      unique case (osc.rate[1:0])
        rtc_pkg::RS_1HZ: osc.sq_level = s_q.div[14];
        rtc_pkg::RS_4K: osc.sq_level = s_q.div[2];
        rtc_pkg::RS_8K: osc.sq_level = s_q.div[1];
        rtc_pkg::RS_32K: osc.sq_level = osc.src_level;
      endcase
  end

  // trim queue, divider and fractional accumulator
  always_comb
  begin
    s_d = s_q;
    if (osc.ce)
    begin
      if (osc.minute_pulse)
        s_d.pend = {osc.trim_val, 1'b0};
      else if (s_q.pend != 9'h000 && (osc.trim_neg ? osc.src_rise : !osc.src_rise))
        s_d.pend = s_q.pend - 9'h001;
      if (eff_tick)
      begin
        s_d.div = s_q.div + 15'h0001;
        if (acc_sum >= rtc_pkg::OSC_HZ)
          s_d.acc = 15'(acc_sum - rtc_pkg::OSC_HZ);
        else
          s_d.acc = acc_sum[14:0];
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

endmodule : osc_prescaler

`default_nettype wire

// ==== rtc_core.sv ====
// Purpose: time and configuration registers with BCD calendar counters
// Assumes: register port strobes are one-cycle pulses synchronous to sys_clk_i
// Notes: a register write in the same cycle as a count overrides the count
`timescale 1ns/1ps
`default_nettype none

module rtc_core (
  // clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // timebase and supply
  input wire logic xtal_clk_i,
  input wire logic ext_clk_i,
  input wire logic vcc_fail_i,
  output logic osc_enable_o,
  output logic backup_connect_o,
  // pin and alarms
  output logic multi_function_pin_o,
  output logic [1:0] alarm_enable_field_o,
  output logic alarm0_match_o
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] frac;
    logic osc_run_request;
    logic [6:0] sec;
    logic [6:0] min;
    logic trim_direction;
    logic fmt12;
    logic [5:0] hour;
    logic batt_switched;
    logic backup_supply_enable;
    logic [2:0] wday;
    logic [5:0] date;
    logic [4:0] month;
    logic [7:0] year;
    logic [7:0] ctrl;
    logic [7:0] trim_val;
    logic [6:0] a0_sec;
    logic [6:0] a0_min;
    logic [7:0] rdata;
    logic multi_function_pin;
    logic a0_match;
  } core_state_t;

  core_state_t s_q;
  core_state_t s_d;
  logic leap_year_indicator;
  logic osc_running_status;
  logic hund_tick;
  logic sq_level;

  osc_if osc ();

  // ****************************************
  // helpers
  // ****************************************

  // BCD increment with wrap; bit 8 of the result is the carry out
  function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] lim,
                                         input logic [7:0] lo);
    logic [8:0] r;
    r = {1'b0, v};
    if (v >= lim)
      r = {1'b1, lo};
    else if (v[3:0] >= 4'h9)
      r = {1'b0, v[7:4] + 4'h1, 4'h0};
    else
      r = {1'b0, v[7:4], v[3:0] + 4'h1};
    return r;
  endfunction : bcd_inc

  // last day of a BCD month
  function automatic logic [7:0] month_len(input logic [4:0] m, input logic leap);
    logic [7:0] r;
    r = 8'h31;
    unique case (m)
      5'h02: r = leap ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: r = 8'h30;
      default: r = 8'h31;
    endcase
    return r;
  endfunction : month_len

  // BCD year divisible by four
  always_comb
  begin
    if (s_q.year[4])
      leap_year_indicator = (s_q.year[3:0] == 4'h2) || (s_q.year[3:0] == 4'h6);
    else
      leap_year_indicator = (s_q.year[3:0] == 4'h0) || (s_q.year[3:0] == 4'h4)
                            || (s_q.year[3:0] == 4'h8);
  end

  // ****************************************
  // timebase helpers
  // ****************************************
  assign osc.ce = ce_i;
  assign osc.run_req = s_q.osc_run_request;
  assign osc.src_level = s_q.ctrl[rtc_pkg::BIT_EXT] ? ext_clk_i : xtal_clk_i;
  assign osc.trim_neg = s_q.trim_direction;
  assign osc.trim_val = s_q.trim_val;
  assign osc.rate = s_q.ctrl[2:0];
  assign osc_running_status = osc.running;
  assign hund_tick = osc.hund_tick;
  assign sq_level = osc.sq_level;

  osc_monitor u_monitor (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .osc(osc.monitor)
  );

  osc_prescaler u_prescaler (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .osc(osc.prescale)
  );

  // ****************************************
  // next state
  // ****************************************
  logic [8:0] frac_n;
  logic [8:0] sec_n;
  logic [8:0] min_n;
  logic [8:0] hour_n;
  logic [8:0] date_n;
  logic [8:0] month_n;
  logic [8:0] year_n;
  logic [8:0] wday_n;
  logic [4:0] h12;
  logic pm_n;
  logic day_carry;

  // counter chain increments
  always_comb
  begin
    frac_n = bcd_inc(s_q.frac, rtc_pkg::BCD_99, rtc_pkg::RST_ZERO);
    sec_n = bcd_inc({1'b0, s_q.sec}, rtc_pkg::BCD_59, rtc_pkg::RST_ZERO);
    min_n = bcd_inc({1'b0, s_q.min}, rtc_pkg::BCD_59, rtc_pkg::RST_ZERO);
    wday_n = bcd_inc({5'h00, s_q.wday}, rtc_pkg::BCD_7, rtc_pkg::RST_ONE);
    date_n = bcd_inc({2'h0, s_q.date}, month_len(s_q.month, leap_year_indicator),
                     rtc_pkg::RST_ONE);
    month_n = bcd_inc({3'h0, s_q.month}, rtc_pkg::BCD_12, rtc_pkg::RST_ONE);
    year_n = bcd_inc(s_q.year, rtc_pkg::BCD_99, rtc_pkg::RST_ZERO);
    h12 = s_q.hour[4:0];
    pm_n = s_q.hour[rtc_pkg::BIT_PM];
    day_carry = 1'b0;
    if (s_q.fmt12)
    begin
      // 12-hour: 11 -> 12 flips AM/PM, 12 -> 01 without carry
      if ({3'h0, h12} == rtc_pkg::BCD_11)
      begin
        h12 = rtc_pkg::BCD_12[4:0];
        pm_n = ~s_q.hour[rtc_pkg::BIT_PM];
        day_carry = s_q.hour[rtc_pkg::BIT_PM];
      end
      else if ({3'h0, h12} >= rtc_pkg::BCD_12)
        h12 = rtc_pkg::RST_ONE[4:0];
      else
        h12 = 5'(bcd_inc({3'h0, h12}, rtc_pkg::BCD_12, rtc_pkg::RST_ONE));
      hour_n = {3'h0, pm_n, h12};
    end
    else
    begin
      hour_n = bcd_inc({2'h0, s_q.hour}, rtc_pkg::BCD_23, rtc_pkg::RST_ZERO);
      day_carry = hour_n[8];
    end
  end

  // counting, register writes, read data and pin
  always_comb
  begin
    s_d = s_q;
    osc.minute_pulse = 1'b0;
    if (ce_i)
    begin
      // calendar roll-over with carries
      if (hund_tick)
      begin
        s_d.frac = frac_n[7:0];
        if (frac_n[8])
        begin
          s_d.sec = sec_n[6:0];
          if (sec_n[8])
          begin
            osc.minute_pulse = 1'b1;
            s_d.min = min_n[6:0];
            if (min_n[8])
            begin
              s_d.hour = hour_n[5:0];
              if (day_carry)
              begin
                s_d.wday = wday_n[2:0];
                s_d.date = date_n[5:0];
                if (date_n[8])
                begin
                  s_d.month = month_n[4:0];
                  if (month_n[8])
                    s_d.year = year_n[7:0];
                end
              end
            end
          end
        end
      end
      // software writes store any value
      if (reg_wr_i)
      begin
        unique case (reg_addr_i)
          rtc_pkg::ADDR_FRAC: s_d.frac = reg_wdata_i;
          rtc_pkg::ADDR_SEC:
          begin
            s_d.osc_run_request = reg_wdata_i[rtc_pkg::BIT_RUN_REQ];
            s_d.sec = reg_wdata_i[6:0];
          end
          rtc_pkg::ADDR_MIN: s_d.min = reg_wdata_i[6:0];
          rtc_pkg::ADDR_HOUR:
          begin
            s_d.trim_direction = reg_wdata_i[rtc_pkg::BIT_TRIM_DIR];
            s_d.fmt12 = reg_wdata_i[rtc_pkg::BIT_FMT12];
            s_d.hour = reg_wdata_i[5:0];
          end
          rtc_pkg::ADDR_WDAY:
          begin
            if (!reg_wdata_i[rtc_pkg::BIT_BATT])
              s_d.batt_switched = 1'b0;
            s_d.backup_supply_enable = reg_wdata_i[rtc_pkg::BIT_BKUP_EN];
            s_d.wday = reg_wdata_i[2:0];
          end
          rtc_pkg::ADDR_DATE: s_d.date = reg_wdata_i[5:0];
          rtc_pkg::ADDR_MONTH: s_d.month = reg_wdata_i[4:0];
          rtc_pkg::ADDR_YEAR: s_d.year = reg_wdata_i;
          rtc_pkg::ADDR_CTRL: s_d.ctrl = reg_wdata_i;
          rtc_pkg::ADDR_TRIM: s_d.trim_val = reg_wdata_i;
          rtc_pkg::ADDR_A0SEC: s_d.a0_sec = reg_wdata_i[6:0];
          rtc_pkg::ADDR_A0MIN: s_d.a0_min = reg_wdata_i[6:0];
          default: s_d.frac = s_d.frac;
        endcase
      end
      // supply failure sets the flag while backup is enabled, and wins over a clear
      if (vcc_fail_i && s_q.backup_supply_enable)
        s_d.batt_switched = 1'b1;
      // read data with unused bits as zero
      if (reg_rd_i)
      begin
        unique case (reg_addr_i)
          rtc_pkg::ADDR_FRAC: s_d.rdata = s_q.frac;
          rtc_pkg::ADDR_SEC: s_d.rdata = {s_q.osc_run_request, s_q.sec};
          rtc_pkg::ADDR_MIN: s_d.rdata = {1'b0, s_q.min};
          rtc_pkg::ADDR_HOUR: s_d.rdata = {s_q.trim_direction, s_q.fmt12, s_q.hour};
          rtc_pkg::ADDR_WDAY: s_d.rdata = {2'h0, osc_running_status, s_q.batt_switched,
                                           s_q.backup_supply_enable, s_q.wday};
          rtc_pkg::ADDR_DATE: s_d.rdata = {2'h0, s_q.date};
          rtc_pkg::ADDR_MONTH: s_d.rdata = {2'h0, leap_year_indicator, s_q.month};
          rtc_pkg::ADDR_YEAR: s_d.rdata = s_q.year;
          rtc_pkg::ADDR_CTRL: s_d.rdata = s_q.ctrl;
          rtc_pkg::ADDR_TRIM: s_d.rdata = s_q.trim_val;
          rtc_pkg::ADDR_A0SEC: s_d.rdata = {1'b0, s_q.a0_sec};
          rtc_pkg::ADDR_A0MIN: s_d.rdata = {1'b0, s_q.a0_min};
          default: s_d.rdata = rtc_pkg::RST_ZERO;
        endcase
      end
      // pin: divided clock or static polarity level
      if (s_q.ctrl[rtc_pkg::BIT_SQUARE_WAVE_ENABLE])
        s_d.multi_function_pin = sq_level;
      else
        s_d.multi_function_pin = s_q.ctrl[rtc_pkg::BIT_POL];
      // alarm 0 seconds and minutes compare
      s_d.a0_match = s_q.ctrl[4] && (s_q.sec == s_q.a0_sec)
                     && (s_q.min == s_q.a0_min);
    end
  end

  // ****************************************
  // state register and outputs
  // ****************************************

  // register with calendar starting at day 1 of month 1
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
      s_q.wday <= rtc_pkg::RST_ONE[2:0];
      s_q.date <= rtc_pkg::RST_ONE[5:0];
      s_q.month <= rtc_pkg::RST_ONE[4:0];
    end
    else
      s_q <= s_d;
  end

  // outputs from flops
  assign reg_rdata_o = s_q.rdata;
  assign osc_enable_o = s_q.osc_run_request & ~s_q.ctrl[rtc_pkg::BIT_EXT];
  assign backup_connect_o = s_q.backup_supply_enable;
  assign multi_function_pin_o = s_q.multi_function_pin;
  assign alarm_enable_field_o = s_q.ctrl[5:4];
  assign alarm0_match_o = s_q.a0_match;

endmodule : rtc_core

`default_nettype wire

// ==== rtc_core_asserts.sv ====
// Purpose: concurrent checks on the register block ports
// Assumes: shadows track accepted writes of start, backup and control bits
// Notes: bound from the bench top file
`timescale 1ns/1ps
`default_nettype none

module rtc_core_asserts (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // register port
  input wire logic ce_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // timebase, supply and pin
  input wire logic xtal_clk_i,
  input wire logic ext_clk_i,
  input wire logic vcc_fail_i,
  input wire logic osc_enable_o,
  input wire logic backup_connect_o,
  input wire logic multi_function_pin_o,
  input wire logic [1:0] alarm_enable_field_o,
  input wire logic alarm0_match_o
);
  logic st_q;
  logic bk_q;
  logic [7:0] ctrl_q;
  logic wr_en;
  logic rd_en;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  // strobes count only while enabled
  assign wr_en = reg_wr_i & ce_i;
  assign rd_en = reg_rd_i & ce_i;

  // readable bits of each offset
  function automatic logic [7:0] rmask(logic [7:0] a);
    case (a)
      8'h00, 8'h01, 8'h03, 8'h07, 8'h08, 8'h09: rmask = 8'hFF;
      8'h02, 8'h0C, 8'h0D: rmask = 8'h7F;
      8'h04, 8'h05, 8'h06: rmask = 8'h3F;
      default: rmask = 8'h00;
    endcase
  endfunction : rmask

  // shadows of written control bits
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      st_q <= 1'b0;
      bk_q <= 1'b0;
      ctrl_q <= 8'h00;
    end
    else if (wr_en)
    begin
      if (reg_addr_i == rtc_pkg::ADDR_SEC)
        st_q <= reg_wdata_i[7];
      if (reg_addr_i == rtc_pkg::ADDR_WDAY)
        bk_q <= reg_wdata_i[3];
      if (reg_addr_i == rtc_pkg::ADDR_CTRL)
        ctrl_q <= reg_wdata_i;
    end
  end

  a_osc_gate: assert property (osc_enable_o == (st_q & ~ctrl_q[3]))
    else $error("osc enable mismatch");
  a_alarm_field: assert property (alarm_enable_field_o == ctrl_q[5:4])
    else $error("alarm field mismatch");
  a_backup_pin: assert property (backup_connect_o == bk_q)
    else $error("backup connect mismatch");
  a_pin_idle: assert property (!ctrl_q[6] |=> multi_function_pin_o == $past(ctrl_q[7]))
    else $error("pin idle level wrong");
  a_pin_raw: assert property (ctrl_q[6] && ctrl_q[2:0] == 3'h3 && !ctrl_q[3]
    |=> multi_function_pin_o == $past(xtal_clk_i))
    else $error("pin raw rate wrong");
  a_ctrl_read: assert property (rd_en && reg_addr_i == rtc_pkg::ADDR_CTRL
    |=> reg_rdata_o == $past(ctrl_q))
    else $error("control readback wrong");
  a_unused_zero: assert property (rd_en
    |=> (reg_rdata_o & ~rmask($past(reg_addr_i))) == 8'h00)
    else $error("unused bits not zero");
  a_status_stop: assert property (rd_en && reg_addr_i == rtc_pkg::ADDR_WDAY && !st_q
    && !$past(st_q) && !$past(st_q, 2) |=> !reg_rdata_o[5])
    else $error("running status while stopped");
  a_alarm_off: assert property (!ctrl_q[4] && !$past(ctrl_q[4]) |-> !alarm0_match_o)
    else $error("alarm match while disabled");
endmodule : rtc_core_asserts

`default_nettype wire

// ==== xtal_model.sv ====
// Purpose: crystal timebase model for the register block
// Assumes: level changes just after sys_clk_i edges
// Notes: stands still while the oscillator is disabled
`timescale 1ns/1ps
`default_nettype none

module xtal_model #(
  parameter int HALF_CYC = 4
) (
  // clock
  input wire logic sys_clk_i,
  // oscillator enable and level
  input wire logic osc_enable_i,
  output logic xtal_clk_o
);
  int cnt_q = 0;

  initial xtal_clk_o = 1'b0;

  // toggle every HALF_CYC cycles while enabled
  always @(posedge sys_clk_i)
  begin
    if (!osc_enable_i)
      cnt_q <= 0;
    else if (cnt_q == HALF_CYC - 1)
    begin
      cnt_q <= 0;
      xtal_clk_o <= ~xtal_clk_o;
    end
    else
      cnt_q <= cnt_q + 1;
  end
endmodule : xtal_model

`default_nettype wire

// ==== test_rtc_core.sv ====
// Purpose: self-checking bench for the register block
// Assumes: crystal period 8 cycles, external timebase period 10 cycles
// Notes: carry runs preset a time and poll the fraction byte
`timescale 1ns/1ps
`default_nettype none

module test_rtc_core;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic ext_clk_i = 1'b0;
  logic vcc_fail_i = 1'b0;
  logic xtal_clk_i;
  logic osc_enable_o;
  logic backup_connect_o;
  logic multi_function_pin_o;
  logic alarm0_match_o;
  logic [1:0] alarm_enable_field_o;
  logic [7:0] reg_rdata_o;
  logic [7:0] rv;
  int error_cnt = 0;
  int num_checks = 0;
  int ext_cnt = 0;
  logic [7:0] rnd_a [11] = '{8'h00, 8'h02, 8'h03, 8'h05, 8'h08, 8'h09,
    8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E};
  int tog_e [8] = '{0, 16, 32, 128, 0, 0, 0, 0};
  logic [7:0] run_a [8] = '{8'h00, 8'h07, 8'h06, 8'h05, 8'h04, 8'h03, 8'h02, 8'h01};
  logic [7:0] run_i [2][8] = '{'{8'h99, 8'h99, 8'h12, 8'h31, 8'h07, 8'h23, 8'h59, 8'hD9},
    '{8'h99, 8'h23, 8'h02, 8'h28, 8'h03, 8'h71, 8'h59, 8'hD9}};
  logic [7:0] run_e [2][8] = '{'{8'h00, 8'h00, 8'h21, 8'h01, 8'h21, 8'h00, 8'h00, 8'h80},
    '{8'h00, 8'h23, 8'h03, 8'h01, 8'h24, 8'h52, 8'h00, 8'h80}};

  // system clock
  always #12.5 sys_clk_i = ~sys_clk_i;

  // free-running external timebase
  always @(posedge sys_clk_i)
  begin
    ext_cnt <= (ext_cnt == 4) ? 0 : ext_cnt + 1;
    if (ext_cnt == 4)
      ext_clk_i <= ~ext_clk_i;
  end

  rtc_core DUT (.sys_clk_i, .rst_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .xtal_clk_i, .ext_clk_i, .vcc_fail_i, .osc_enable_o,
    .backup_connect_o, .multi_function_pin_o, .alarm_enable_field_o, .alarm0_match_o);
  xtal_model #(.HALF_CYC(4)) u_xtal (.sys_clk_i, .osc_enable_i(osc_enable_o),
    .xtal_clk_o(xtal_clk_i));

  task automatic finish_test;
    $display("errors %0d checks %0d", error_cnt, num_checks);
    if (error_cnt == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  task automatic chk_reg(string n, logic [7:0] e, logic [7:0] s);
    num_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk_reg

  task automatic chk_bit(string n, logic e, logic s);
    num_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("BAD %s exp %b got %b", n, e, s);
    end
  endtask : chk_bit

  task automatic cyc(int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : cyc

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(logic [7:0] a);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 rv = reg_rdata_o;
  endtask : rd

  // expected readback of a written byte
  function automatic logic [7:0] msk(logic [7:0] a);
    case (a)
      8'h02, 8'h0C, 8'h0D: msk = 8'h7F;
      8'h05: msk = 8'h3F;
      8'h0A, 8'h0B, 8'h0E: msk = 8'h00;
      default: msk = 8'hFF;
    endcase
  endfunction : msk

  function automatic logic leap(logic [7:0] y);
    leap = ((y[7:4] * 10 + y[3:0]) % 4) == 0;
  endfunction : leap

  function automatic logic [7:0] rst_val(logic [7:0] a);
    rst_val = (a == 8'h04 || a == 8'h05) ? 8'h01 : (a == 8'h06) ? {2'h0, leap(8'h00), 5'h01} : 8'h00;
  endfunction : rst_val

  task automatic chk_rst;
    for (int a = 0; a < 15; a++)
    begin
      rd(8'(a));
      chk_reg("reset value", rst_val(8'(a)), rv);
    end
  endtask : chk_rst

  // preset a time, start, wait for the next hundredth and read the carry
  task automatic run(int k);
    int n = 0;
    wr(8'h01, 8'h00);
    for (int i = 0; i < 8; i++)
      wr(run_a[i], run_i[k][i]);
    do
    begin
      rd(8'h00);
      n++;
    end
    while (rv === 8'h99 && n < 3000);
    if (n == 3000)
    begin
      error_cnt++;
      finish_test();
    end
    cyc(300);
    for (int i = 0; i < 8; i++)
    begin
      rd(run_a[i]);
      chk_reg("carry", run_e[k][i], rv);
    end
  endtask : run

  // main sequence
  initial
  begin
    logic [7:0] a;
    logic [7:0] d;
    int cnt;
    logic last;
    void'($urandom(32'h4ED31B06));
    cyc(12);
    rst_i <= 1'b0;
    chk_rst();
    for (int i = 0; i < 24; i++)
    begin
      a = rnd_a[$urandom % 11];
      d = 8'($urandom);
      wr(a, d);
      rd(a);
      chk_reg("readback", d & msk(a), rv);
    end
    wr(8'h04, 8'hFF);
    rd(8'h04);
    chk_reg("weekday", 8'h0F, rv);
    chk_bit("backup", 1'b1, backup_connect_o);
    vcc_fail_i <= 1'b1;
    cyc(2);
    rd(8'h04);
    chk_reg("battery set", 8'h1F, rv);
    vcc_fail_i <= 1'b0;
    wr(8'h04, 8'h1F);
    rd(8'h04);
    chk_reg("battery kept", 8'h1F, rv);
    wr(8'h04, 8'h07);
    vcc_fail_i <= 1'b1;
    cyc(2);
    rd(8'h04);
    chk_reg("battery clear", 8'h07, rv);
    chk_bit("backup", 1'b0, backup_connect_o);
    vcc_fail_i <= 1'b0;
    wr(8'h09, 8'h5A);
    ce_i <= 1'b0;
    wr(8'h09, 8'hA5);
    ce_i <= 1'b1;
    rd(8'h09);
    chk_reg("frozen write", 8'h5A, rv);
    rst_i <= 1'b1;
    cyc(2);
    rst_i <= 1'b0;
    chk_rst();
    for (int i = 0; i < 6; i++)
    begin
      d = 8'((($urandom % 10) << 4) | ($urandom % 10));
      wr(8'h07, d);
      rd(8'h06);
      chk_reg("month", {2'h0, leap(d), 5'h01}, rv);
    end
    wr(8'h01, 8'h80);
    chk_bit("osc enable", 1'b1, osc_enable_o);
    cyc(240);
    rd(8'h04);
    chk_reg("status early", 8'h01, rv);
    cyc(40);
    rd(8'h04);
    chk_reg("status set", 8'h21, rv);
    wr(8'h01, 8'h00);
    cyc(3);
    rd(8'h04);
    chk_reg("status stop", 8'h01, rv);
    wr(8'h08, 8'h08);
    wr(8'h01, 8'h80);
    chk_bit("osc enable", 1'b0, osc_enable_o);
    cyc(400);
    rd(8'h04);
    chk_reg("status ext", 8'h21, rv);
    wr(8'h08, 8'h80);
    cyc(2);
    chk_bit("pin level", 1'b1, multi_function_pin_o);
    wr(8'h08, 8'h00);
    cyc(2);
    chk_bit("pin level", 1'b0, multi_function_pin_o);
    for (int r = 0; r < 8; r++)
    begin
      wr(8'h08, 8'h40 | 8'(r));
      cyc(8);
      cnt = 0;
      last = multi_function_pin_o;
      repeat (512)
      begin
        cyc(1);
        if (multi_function_pin_o !== last)
          cnt++;
        last = multi_function_pin_o;
      end
      chk_bit("pin toggles", 1'b1, cnt + 1 >= tog_e[r] && cnt <= tog_e[r] + 1);
    end
    wr(8'h08, 8'h10);
    wr(8'h0C, 8'h00);
    wr(8'h0D, 8'h00);
    run(0);
    chk_bit("alarm0", 1'b1, alarm0_match_o);
    run(1);
    finish_test();
  end
endmodule : test_rtc_core

bind rtc_core rtc_core_asserts u_chk (.sys_clk_i, .rst_i, .ce_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .reg_rd_i, .reg_rdata_o, .xtal_clk_i, .ext_clk_i, .vcc_fail_i, .osc_enable_o,
  .backup_connect_o, .multi_function_pin_o, .alarm_enable_field_o, .alarm0_match_o);

`default_nettype wire
